// ===== hw/angle_sensor_consts.vh
`ifndef ANGLE_SENSOR_CONSTS_VH
`define ANGLE_SENSOR_CONSTS_VH

// ****************
// Serial bus identity and command codes
// ****************
`define DEV_ADDR 7'h36
`define CMD_BURN_ANGLE 8'h80
`define CMD_BURN_SETTING 8'h40
`define MAX_ANGLE_BURNS 2'h3

// ****************
// Register offsets
// ****************
`define REG_BURN_COUNT 8'h00
`define REG_START_HI 8'h01
`define REG_START_LO 8'h02
`define REG_STOP_HI 8'h03
`define REG_STOP_LO 8'h04
`define REG_SPAN_HI 8'h05
`define REG_SPAN_LO 8'h06
`define REG_SETTINGS_HI 8'h07
`define REG_SETTINGS_LO 8'h08
`define REG_MAGNET_FLAGS 8'h0B
`define REG_UNSCALED_HI 8'h0C
`define REG_UNSCALED_LO 8'h0D
`define REG_SCALED_HI 8'h0E
`define REG_SCALED_LO 8'h0F
`define REG_GAIN_LEVEL 8'h1A
`define REG_STRENGTH_HI 8'h1B
`define REG_STRENGTH_LO 8'h1C
`define REG_OTP_COMMAND 8'hFF

// ****************
// Writable bit masks, reserved bits keep their loaded value
// ****************
`define MASK_NIBBLE_HI 8'h0F
`define MASK_FULL_BYTE 8'hFF
`define MASK_SETTINGS_HI 8'h3F

// ****************
// Field positions inside the settings word and the magnet flags byte
// ****************
`define POWER_LEVEL_LSB 0
`define DEADBAND_LSB 2
`define OUTPUT_STAGE_LSB 4
`define PULSE_RATE_LSB 6
`define SLOW_FILTER_LSB 8
`define FAST_THRESH_LSB 10
`define WATCHDOG_BIT 13
`define MAG_STRONG_BIT 3
`define MAG_WEAK_BIT 4
`define MAG_DETECTED_BIT 5

// ****************
// One-time memory layout and resolution
// ****************
`define OTP_LAST 4'h9
`define OTP_SETTING_FLAG 4'h9
`define OTP_TALLY_ANGLE 4'h0
`define FULL_TURN_COUNTS 13'h1000
`define HALF_TURN_COUNTS 13'h0800
`define CFG_RESET 8'h00

`endif

// ===== hw/otp_memory.v
`timescale 1ns/1ns
// One-time memory, registered read; RST leaves its content alone
module otp_memory (
  // Clock
  input wire CLK,
  // Write port
  input wire WE,
  input wire [3:0] WADDR,
  input wire [7:0] WDATA,
  // Read port
  input wire [3:0] RADDR,
  output reg [7:0] RDATA
);

  reg [7:0] mem [0:15];
  integer i;

  // ****************
  // Power-up image, never programmed bits read as zero
  // ****************
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      mem[i] = 8'h00;
    end
  end

  // Write and registered read
  always @(posedge CLK) begin
    if (WE) begin
      mem[WADDR] <= WDATA;
    end
    RDATA <= mem[RADDR];
  end

endmodule

// ===== hw/angle_sensor_regs.v
`timescale 1ns/1ns
`include "angle_sensor_consts.vh"
// Function
// R1 - Registers reached over two-wire bus, slave address 0x36.
// R2 - Start, stop and span angles define narrowed output range.
// R3 - Host programs a narrowed range larger than 18 degrees.
// R4 - Full turn is 4096 counts, half turn 2048, no rescaling.
// R5 - Settings 1:0 select normal or low-power levels one to three.
// R6 - Settings 3:2 select no hysteresis or 1, 2, 3 LSB.
// R7 - Settings 5:4 select full analog, limited analog or pulse output.
// R8 - Settings 7:6 select pulse rate 115, 230, 460 or 920 Hz.
// R9 - Settings 9:8 select slow filter factor 16x, 8x, 4x, 2x.
// R10 - Settings 12:10 select slow-only or fast-filter thresholds.
// R11 - Settings bit 13 switches the watchdog off or on.
// R12 - Host changes settings by read, modify and full write-back.
// R13 - Unassigned configuration bits keep factory values.
// R14 - Power-up loads configuration from one-time memory, blanks zero.
// R15 - Command 0x80 burns angles, 0x40 burns span and settings; code needs magnet detected for 0x80, burns span only at burn count zero.
// R16 - Unassigned reads return zero and still advance the pointer.
// R17 - Pointer holds on high byte of angle and magnitude reads.
// R18 - Writes to unassigned addresses are refused, discarded, pointer moves.
// R19 - Angle burn allowed at most three times, counted in burn count.
// R20 - 12-bit values: upper nibble low at first address, low byte next.
// R21 - Writes to read-only registers leave them unchanged.
module angle_sensor_regs (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Two-wire serial bus
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  // Sensor core results
  input wire [11:0] UNSCALED_ANGLE,
  input wire [11:0] SCALED_ANGLE,
  input wire [11:0] FIELD_STRENGTH,
  input wire [7:0] GAIN_LEVEL,
  input wire MAGNET_DETECTED,
  input wire MAGNET_WEAK,
  input wire MAGNET_STRONG,
  // Configuration to the sensor core
  output wire [11:0] START_ANGLE,
  output wire [11:0] STOP_ANGLE,
  output wire [11:0] SPAN_ANGLE,
  output wire [1:0] POWER_LEVEL_SELECT,
  output wire [1:0] OUTPUT_DEADBAND,
  output wire [1:0] OUTPUT_STAGE_SELECT,
  output wire [1:0] PULSE_RATE_SELECT,
  output wire [1:0] SLOW_FILTER_FACTOR,
  output wire [2:0] FAST_FILTER_THRESHOLD,
  output wire WATCHDOG_ENABLE,
  output reg [4:0] FAST_THRESHOLD_LSB,
  output reg [9:0] PULSE_RATE_HZ,
  output reg [4:0] SLOW_FILTER_DIV,
  // Status
  output wire [1:0] BURN_COUNT,
  output reg CONFIG_READY,
  output reg BURN_BUSY
);

  // ****************
  // States
  // ****************
  localparam B_IDLE = 7'h01;
  localparam B_ADDR = 7'h02;
  localparam B_AACK = 7'h04;
  localparam B_WR = 7'h08;
  localparam B_WACK = 7'h10;
  localparam B_RD = 7'h20;
  localparam B_RACK = 7'h40;
  localparam S_LOAD = 4'h1;
  localparam S_RUN = 4'h2;
  localparam S_BURN = 4'h4;
  localparam S_TALLY = 4'h8;

  reg scl_s1_ff, scl_s2_ff, scl_s3_ff;
  reg sda_s1_ff, sda_s2_ff, sda_s3_ff;
  reg [6:0] bst_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] tx_ff;
  reg [7:0] ptr_ff;
  reg rw_ff, first_ff, mack_ff, sda_oe_ff, sda_out_ff;
  reg wr_stb_ff;
  reg [7:0] wr_addr_ff, wr_data_ff;
  reg [7:0] cfg_ff [0:9];
  reg [3:0] ctl_ff, cur_ff, end_ff, tally_ff, cap_idx_ff;
  reg [7:0] tally_val_ff;
  reg cap_ff;
  reg [7:0] rd_data;
  reg [3:0] mem_addr;
  wire [7:0] mem_rdata;
  wire scl_rise, scl_fall, bus_start, bus_stop;
  wire [15:0] settings;
  integer i;

  // ****************
  // Address decoding
  // ****************
  // Readable locations of the map
  function readable;
    input [7:0] a;
    begin
      readable = (a <= `REG_SETTINGS_LO) ||
        (a >= `REG_MAGNET_FLAGS && a <= `REG_SCALED_LO) ||
        (a >= `REG_GAIN_LEVEL && a <= `REG_STRENGTH_LO);
    end
  endfunction

  // Locations that accept written data: stored bytes and the command
  function writable;
    input [7:0] a;
    begin
      writable = (a >= `REG_START_HI && a <= `REG_SETTINGS_LO) ||
        (a == `REG_OTP_COMMAND);
    end
  endfunction

  // Bits a write may change; reserved bits keep their loaded value
  function [7:0] wmask;
    input [7:0] a;
    begin
      case (a)
        `REG_START_HI, `REG_STOP_HI, `REG_SPAN_HI: wmask = `MASK_NIBBLE_HI;
        `REG_SETTINGS_HI: wmask = `MASK_SETTINGS_HI;
        default: wmask = `MASK_FULL_BYTE;
      endcase
    end
  endfunction

  // ****************
  // Bus input synchronisers and condition detection
  // ****************
  // Two stages before any logic; third stage only for edges
  always @(posedge CLK) begin
    if (RST) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
    end else begin
      scl_s1_ff <= SCL_IN;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= SDA_IN;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
    end
  end

  assign scl_rise = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall = ~scl_s2_ff & scl_s3_ff;
  assign bus_start = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
  assign bus_stop = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;

  // ****************
  // Read data at the pointer
  // ****************
  // Unassigned and write-only locations read as zero
  always @* begin
    rd_data = 8'h00; // R16
    case (ptr_ff)
      `REG_BURN_COUNT: rd_data = cfg_ff[0];
      `REG_START_HI: rd_data = cfg_ff[1];
      `REG_START_LO: rd_data = cfg_ff[2];
      `REG_STOP_HI: rd_data = cfg_ff[3];
      `REG_STOP_LO: rd_data = cfg_ff[4];
      `REG_SPAN_HI: rd_data = cfg_ff[5];
      `REG_SPAN_LO: rd_data = cfg_ff[6];
      `REG_SETTINGS_HI: rd_data = cfg_ff[7];
      `REG_SETTINGS_LO: rd_data = cfg_ff[8];
      `REG_MAGNET_FLAGS: rd_data = {2'h0, MAGNET_DETECTED, MAGNET_WEAK,
                                     MAGNET_STRONG, 3'h0};
      `REG_UNSCALED_HI: rd_data = {4'h0, UNSCALED_ANGLE[11:8]}; // R20
      `REG_UNSCALED_LO: rd_data = UNSCALED_ANGLE[7:0]; // R20
      `REG_SCALED_HI: rd_data = {4'h0, SCALED_ANGLE[11:8]};
      `REG_SCALED_LO: rd_data = SCALED_ANGLE[7:0];
      `REG_GAIN_LEVEL: rd_data = GAIN_LEVEL;
      `REG_STRENGTH_HI: rd_data = {4'h0, FIELD_STRENGTH[11:8]};
      `REG_STRENGTH_LO: rd_data = FIELD_STRENGTH[7:0];
      default: rd_data = 8'h00;
    endcase
  end

  // ****************
  // Serial bus slave
  // ****************
  // Bits sampled on SCL rise, driven after SCL fall; START and STOP
  // win over every bus state. The bus is ignored while memory loads.
  always @(posedge CLK) begin
    if (RST) begin
      bst_ff <= B_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      mack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else begin
      wr_stb_ff <= 1'b0;
      if (ctl_ff == S_LOAD) begin
        bst_ff <= B_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (bus_start) begin
        bst_ff <= B_ADDR;
        bit_cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
      end else if (bus_stop) begin
        bst_ff <= B_IDLE;
        sda_oe_ff <= 1'b0;
      end else begin
        case (bst_ff)
          B_ADDR, B_WR: begin
            if (scl_rise && bit_cnt_ff != 4'h8) begin
              shift_ff <= {shift_ff[6:0], sda_s2_ff};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              bit_cnt_ff <= 4'h0;
              if (bst_ff == B_ADDR) begin
                if (shift_ff[7:1] == `DEV_ADDR) begin // R1
                  sda_oe_ff <= 1'b1;
                  rw_ff <= shift_ff[0];
                  first_ff <= ~shift_ff[0];
                  bst_ff <= B_AACK;
                end else begin
                  bst_ff <= B_IDLE;
                end
              end else if (first_ff) begin
                // Pointer load; unknown locations are not acknowledged
                ptr_ff <= shift_ff;
                first_ff <= 1'b0;
                sda_oe_ff <= readable(shift_ff) |
                  (shift_ff == `REG_OTP_COMMAND);
                bst_ff <= B_WACK;
              end else begin
                sda_oe_ff <= writable(ptr_ff); // R18 R21
                wr_stb_ff <= writable(ptr_ff); // R18 R21
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= shift_ff;
                ptr_ff <= ptr_ff + 8'h01; // R18
                bst_ff <= B_WACK;
              end
            end
          end
          B_AACK, B_RACK: begin
            if (scl_rise) begin
              mack_ff <= ~sda_s2_ff;
            end else if (scl_fall) begin
              if (rw_ff && (bst_ff == B_AACK || mack_ff)) begin
                tx_ff <= rd_data;
                sda_oe_ff <= ~rd_data[7];
                bit_cnt_ff <= 4'h1;
                bst_ff <= B_RD;
                // Hold on high byte so a poll needs no reload
                if (ptr_ff != `REG_UNSCALED_HI &&
                    ptr_ff != `REG_SCALED_HI &&
                    ptr_ff != `REG_STRENGTH_HI) begin // R17
                  ptr_ff <= ptr_ff + 8'h01; // R16
                end
              end else if (rw_ff) begin
                sda_oe_ff <= 1'b0; // Master NACK ends the read
                bst_ff <= B_IDLE;
              end else begin
                sda_oe_ff <= 1'b0;
                bst_ff <= B_WR;
              end
            end
          end
          B_WACK: begin
            if (scl_fall) begin
              sda_oe_ff <= 1'b0;
              bst_ff <= B_WR;
            end
          end
          B_RD: begin
            if (scl_fall) begin
              if (bit_cnt_ff == 4'h8) begin
                sda_oe_ff <= 1'b0;
                bst_ff <= B_RACK;
              end else begin
                sda_oe_ff <= ~tx_ff[6];
                tx_ff <= {tx_ff[6:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          default: begin
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************
  // Configuration shadow, power-up load and burn sequencer
  // ****************
  // Memory read address during load, write address during burn
  always @* begin
    mem_addr = cur_ff;
    if (ctl_ff == S_TALLY) begin
      mem_addr = tally_ff;
    end
  end

  otp_memory u_otp (
    .CLK(CLK),
    .WE(ctl_ff == S_BURN || ctl_ff == S_TALLY),
    .WADDR(mem_addr),
    .WDATA(ctl_ff == S_TALLY ? tally_val_ff : cfg_ff[cur_ff]),
    .RADDR(mem_addr),
    .RDATA(mem_rdata)
  );

  // Loads shadow after reset, takes bus writes, runs burns
  always @(posedge CLK) begin
    if (RST) begin
      for (i = 0; i < 10; i = i + 1) begin
        cfg_ff[i] <= `CFG_RESET;
      end
      ctl_ff <= S_LOAD;
      cur_ff <= 4'h0;
      end_ff <= 4'h0;
      tally_ff <= 4'h0;
      tally_val_ff <= 8'h00;
      cap_ff <= 1'b0;
      cap_idx_ff <= 4'h0;
      CONFIG_READY <= 1'b0;
      BURN_BUSY <= 1'b0;
    end else begin
      cap_ff <= 1'b0;
      if (cap_ff) begin
        cfg_ff[cap_idx_ff] <= mem_rdata; // R14
        CONFIG_READY <= (cap_idx_ff == `OTP_LAST);
      end
      case (ctl_ff)
        S_LOAD: begin
          cap_ff <= 1'b1;
          cap_idx_ff <= cur_ff;
          cur_ff <= cur_ff + 4'h1;
          if (cur_ff == `OTP_LAST) begin
            ctl_ff <= S_RUN;
          end
        end
        S_RUN: begin
          if (wr_stb_ff && wr_addr_ff != `REG_OTP_COMMAND) begin
            // Masked merge keeps reserved bits
            cfg_ff[wr_addr_ff[3:0]] <= (cfg_ff[wr_addr_ff[3:0]] &
              ~wmask(wr_addr_ff)) | (wr_data_ff & wmask(wr_addr_ff)); // R13
          end else if (wr_stb_ff && wr_data_ff == `CMD_BURN_ANGLE &&
              cfg_ff[0][1:0] != `MAX_ANGLE_BURNS &&
              MAGNET_DETECTED) begin // R15 R19
            cur_ff <= 4'h1;
            end_ff <= 4'h4;
            tally_ff <= `OTP_TALLY_ANGLE;
            tally_val_ff <= {cfg_ff[0][7:2], cfg_ff[0][1:0] + 2'h1}; // R19
            ctl_ff <= S_BURN;
            BURN_BUSY <= 1'b1;
          end else if (wr_stb_ff && wr_data_ff == `CMD_BURN_SETTING &&
              cfg_ff[`OTP_SETTING_FLAG] == 8'h00) begin // R15
            // Span is burnt only while angles were never burnt
            cur_ff <= (cfg_ff[0][1:0] == 2'h0) ? 4'h5 : 4'h7;
            end_ff <= 4'h8;
            tally_ff <= `OTP_SETTING_FLAG;
            tally_val_ff <= 8'h01;
            ctl_ff <= S_BURN;
            BURN_BUSY <= 1'b1;
          end
        end
        S_BURN: begin
          cur_ff <= cur_ff + 4'h1;
          if (cur_ff == end_ff) begin
            ctl_ff <= S_TALLY;
          end
        end
        S_TALLY: begin
          cfg_ff[tally_ff] <= tally_val_ff;
          ctl_ff <= S_RUN;
          BURN_BUSY <= 1'b0;
        end
        default: begin
          ctl_ff <= S_RUN;
        end
      endcase
    end
  end

  // ****************
  // Configuration outputs
  // ****************
  // Shadow bytes joined back into 12-bit values
  assign START_ANGLE = {cfg_ff[1][3:0], cfg_ff[2]}; // R2 R20
  assign STOP_ANGLE = {cfg_ff[3][3:0], cfg_ff[4]}; // R2 R20
  assign SPAN_ANGLE = {cfg_ff[5][3:0], cfg_ff[6]}; // R2 R4
  assign settings = {cfg_ff[7], cfg_ff[8]};
  assign POWER_LEVEL_SELECT = settings[`POWER_LEVEL_LSB +: 2]; // R5
  assign OUTPUT_DEADBAND = settings[`DEADBAND_LSB +: 2]; // R6
  assign OUTPUT_STAGE_SELECT = settings[`OUTPUT_STAGE_LSB +: 2]; // R7
  assign PULSE_RATE_SELECT = settings[`PULSE_RATE_LSB +: 2]; // R8
  assign SLOW_FILTER_FACTOR = settings[`SLOW_FILTER_LSB +: 2]; // R9
  assign FAST_FILTER_THRESHOLD = settings[`FAST_THRESH_LSB +: 3]; // R10
  assign WATCHDOG_ENABLE = settings[`WATCHDOG_BIT]; // R11
  assign BURN_COUNT = cfg_ff[0][1:0]; // R19
  assign SDA_OUT = sda_out_ff; // Open drain: only ever pulls low
  assign SDA_OE = sda_oe_ff;

  // Decoded values registered so the core sees stable numbers
  always @(posedge CLK) begin
    if (RST) begin
      FAST_THRESHOLD_LSB <= 5'h00;
      PULSE_RATE_HZ <= 10'h073;
      SLOW_FILTER_DIV <= 5'h10;
    end else begin
      case (FAST_FILTER_THRESHOLD)
        3'h1: FAST_THRESHOLD_LSB <= 5'h06; // R10
        3'h2: FAST_THRESHOLD_LSB <= 5'h07;
        3'h3: FAST_THRESHOLD_LSB <= 5'h09;
        3'h4: FAST_THRESHOLD_LSB <= 5'h12;
        3'h5: FAST_THRESHOLD_LSB <= 5'h15;
        3'h6: FAST_THRESHOLD_LSB <= 5'h18;
        3'h7: FAST_THRESHOLD_LSB <= 5'h0A;
        default: FAST_THRESHOLD_LSB <= 5'h00; // Slow filter only
      endcase
      PULSE_RATE_HZ <= 10'h073 << PULSE_RATE_SELECT; // R8
      SLOW_FILTER_DIV <= 5'h10 >> SLOW_FILTER_FACTOR; // R9
    end
  end

endmodule

// ===== dv/angle_sensor_regs_asserts.sv
`timescale 1ns/1ns
// ********************
// Port checker
// ********************
module angle_sensor_regs_chk (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Bus pin
  input wire SDA_OUT,
  input wire SDA_OE,
  // Configuration
  input wire [11:0] START_ANGLE,
  input wire [11:0] STOP_ANGLE,
  input wire [11:0] SPAN_ANGLE,
  input wire [1:0] PULSE_RATE_SELECT,
  input wire [1:0] SLOW_FILTER_FACTOR,
  input wire [2:0] FAST_FILTER_THRESHOLD,
  input wire [4:0] FAST_THRESHOLD_LSB,
  input wire [9:0] PULSE_RATE_HZ,
  input wire [4:0] SLOW_FILTER_DIV,
  // Status
  input wire [1:0] BURN_COUNT,
  input wire CONFIG_READY,
  input wire BURN_BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Threshold table, code 0 means slow filter only
  wire [39:0] thr_tab = {5'h0A, 5'h18, 5'h15, 5'h12, 5'h09, 5'h07,
    5'h06, 5'h00};
  wire [35:0] angs = {START_ANGLE, STOP_ANGLE, SPAN_ANGLE};
  // Open drain: the pin is only ever pulled low
  property p_sda_low_only;
    SDA_OUT == 1'b0;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only)
    else $error("SDA output not low");
  property p_quiet_until_ready;
    !CONFIG_READY |-> !SDA_OE;
  endproperty
  a_quiet_until_ready: assert property (p_quiet_until_ready)
    else $error("Bus answered before load");
  property p_ready_in_time;
    $fell(RST) |-> ##[1:30] CONFIG_READY;
  endproperty
  a_ready_in_time: assert property (p_ready_in_time)
    else $error("Memory load too slow");
  // Decodes may lag their field by one cycle
  property p_rate_decode;
    $stable(PULSE_RATE_SELECT) |->
      PULSE_RATE_HZ == (10'h073 << PULSE_RATE_SELECT);
  endproperty
  a_rate_decode: assert property (p_rate_decode)
    else $error("Pulse rate decode wrong");
  property p_filter_decode;
    $stable(SLOW_FILTER_FACTOR) |->
      SLOW_FILTER_DIV == (5'h10 >> SLOW_FILTER_FACTOR);
  endproperty
  a_filter_decode: assert property (p_filter_decode)
    else $error("Slow filter decode wrong");
  property p_thresh_decode;
    $stable(FAST_FILTER_THRESHOLD) |->
      FAST_THRESHOLD_LSB == thr_tab[FAST_FILTER_THRESHOLD * 5 +: 5];
  endproperty
  a_thresh_decode: assert property (p_thresh_decode)
    else $error("Threshold decode wrong");
  property p_burn_step;
    $past(CONFIG_READY) && !$stable(BURN_COUNT) |->
      BURN_COUNT == $past(BURN_COUNT) + 2'h1 && $past(BURN_COUNT) != 2'h3;
  endproperty
  a_burn_step: assert property (p_burn_step)
    else $error("Burn count not a single step");
  property p_busy_ends;
    $rose(BURN_BUSY) |-> ##[1:20] !BURN_BUSY;
  endproperty
  a_busy_ends: assert property (p_busy_ends)
    else $error("Burn never finished");
  // Stores only follow an acknowledged byte
  property p_store_on_ack;
    $past(CONFIG_READY) && !$stable(angs) |-> SDA_OE || $past(SDA_OE);
  endproperty
  a_store_on_ack: assert property (p_store_on_ack)
    else $error("Angle changed without acknowledge");
  c_burn_full: cover property (BURN_COUNT == 2'h3);
  c_fth_top: cover property (FAST_FILTER_THRESHOLD == 3'h7);
  c_ack: cover property ($rose(SDA_OE));
endmodule

bind angle_sensor_regs angle_sensor_regs_chk i_angle_sensor_regs_chk (
  .CLK, .RST, .SDA_OUT, .SDA_OE, .START_ANGLE, .STOP_ANGLE, .SPAN_ANGLE,
  .PULSE_RATE_SELECT, .SLOW_FILTER_FACTOR, .FAST_FILTER_THRESHOLD,
  .FAST_THRESHOLD_LSB, .PULSE_RATE_HZ, .SLOW_FILTER_DIV, .BURN_COUNT,
  .CONFIG_READY, .BURN_BUSY);

// ===== dv/bus_host.sv
`timescale 1ns/1ns
// ********************
// Bus master model
// ********************
module bus_host (
  // Clock
  input wire clk,
  // Resolved data wire
  input wire sda,
  // Driven pins, SCL stops high between frames
  output reg scl = 1'b1,
  output reg sda_low = 1'b0
);
  // Quarter bit, two CLK, so one bit takes 400 ns
  task q;
    repeat (2) @(posedge clk);
  endtask
  // Start or repeated start: SDA falls with SCL high
  task start;
    sda_low <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  // Stop: SDA rises with SCL high
  task stop;
    sda_low <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b0;
    q;
  endtask
  // Nine bits MSB first; SDA moves only while SCL is low
  task xfer(input [8:0] d, output [8:0] r);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      sda_low <= !d[i];
      q;
      scl <= 1'b1;
      q;
      r[i] = sda;
      q;
      scl <= 1'b0;
      q;
    end
  endtask
endmodule

// ===== dv/angle_sensor_regs_tb.sv
`timescale 1ns/1ns
`include "angle_sensor_consts.vh"
module angle_sensor_regs_tb;
  // ********************
  // Pins and state
  // ********************
  reg CLK = 1'b0;
  reg RST = 1'b1;
  reg [11:0] UNSCALED_ANGLE = 12'h000;
  reg [11:0] SCALED_ANGLE = 12'h000;
  reg [11:0] FIELD_STRENGTH = 12'h000;
  reg [7:0] GAIN_LEVEL = 8'h00;
  reg MAGNET_DETECTED = 1'b0;
  reg MAGNET_WEAK = 1'b0;
  reg MAGNET_STRONG = 1'b0;
  wire scl, sda_low, SDA_OUT, SDA_OE, WATCHDOG_ENABLE;
  wire CONFIG_READY, BURN_BUSY;
  wire [11:0] START_ANGLE, STOP_ANGLE, SPAN_ANGLE;
  wire [1:0] POWER_LEVEL_SELECT, OUTPUT_DEADBAND, OUTPUT_STAGE_SELECT;
  wire [1:0] PULSE_RATE_SELECT, SLOW_FILTER_FACTOR, BURN_COUNT;
  wire [2:0] FAST_FILTER_THRESHOLD;
  wire [4:0] FAST_THRESHOLD_LSB, SLOW_FILTER_DIV;
  wire [9:0] PULSE_RATE_HZ;
  // Pull-up wire, low when either party pulls
  wire sda = (SDA_OE ? SDA_OUT : 1'b1) & !sda_low;
  wire [35:0] angs = {START_ANGLE, STOP_ANGLE, SPAN_ANGLE};
  wire [13:0] fields = {WATCHDOG_ENABLE, FAST_FILTER_THRESHOLD,
    SLOW_FILTER_FACTOR, PULSE_RATE_SELECT, OUTPUT_STAGE_SELECT,
    OUTPUT_DEADBAND, POWER_LEVEL_SELECT};
  integer failures, tests_run, k, n;
  reg [8:0] r;
  reg [7:0] h, l;
  reg [11:0] v;
  reg [13:0] sv;
  reg [11:0] va [0:2];
  reg [31:0] seed;

  always #25 CLK = ~CLK;

  angle_sensor_regs i_angle_sensor_regs (.CLK, .RST, .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT, .SDA_OE, .UNSCALED_ANGLE, .SCALED_ANGLE,
    .FIELD_STRENGTH, .GAIN_LEVEL, .MAGNET_DETECTED, .MAGNET_WEAK,
    .MAGNET_STRONG, .START_ANGLE, .STOP_ANGLE, .SPAN_ANGLE,
    .POWER_LEVEL_SELECT, .OUTPUT_DEADBAND, .OUTPUT_STAGE_SELECT,
    .PULSE_RATE_SELECT, .SLOW_FILTER_FACTOR, .FAST_FILTER_THRESHOLD,
    .WATCHDOG_ENABLE, .FAST_THRESHOLD_LSB, .PULSE_RATE_HZ,
    .SLOW_FILTER_DIV, .BURN_COUNT, .CONFIG_READY, .BURN_BUSY);
  bus_host i_bus_host (.clk(CLK), .sda, .scl, .sda_low);

  // Compare and count
  task check(input [63:0] seen, input [63:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict, end of run
  task finish_test;
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for load done or burn done
  task waitfor(input busy);
    for (n = 0; n < 200 && (busy ? BURN_BUSY !== 1'b0 :
        CONFIG_READY !== 1'b1); n = n + 1)
      @(posedge CLK);
    if (n == 200) begin
      failures = failures + 1;
      finish_test;
    end
  endtask
  // Address for writing, then pointer with the expected answer
  task setp(input [7:0] p, input pa);
    i_bus_host.start;
    i_bus_host.xfer({`DEV_ADDR, 2'h1}, r);
    check(r[0], 1'b0);
    i_bus_host.xfer({p, 1'b1}, r);
    check(r[0], !pa);
  endtask
  task wrb(input [7:0] d, input a);
    i_bus_host.xfer({d, 1'b1}, r);
    check(r[0], !a);
  endtask
  task rstart;
    i_bus_host.start;
    i_bus_host.xfer({`DEV_ADDR, 2'h3}, r);
    check(r[0], 1'b0);
  endtask
  // Last byte of a read ends with no acknowledge
  task rdb(input last, output [7:0] d);
    i_bus_host.xfer({8'hFF, last}, r);
    d = r[8:1];
  endtask
  task rd2(input [7:0] p);
    setp(p, 1'b1);
    rstart;
    rdb(1'b0, h);
    rdb(1'b1, l);
    i_bus_host.stop;
  endtask
  task wr2(input [7:0] p, input [7:0] hi, input [7:0] lo);
    setp(p, 1'b1);
    wrb(hi, 1'b1);
    wrb(lo, 1'b1);
    i_bus_host.stop;
  endtask
  // Commands are acked even when refused
  task cmd(input [7:0] c);
    setp(8'hFF, 1'b1);
    i_bus_host.xfer({c, 1'b1}, r);
    i_bus_host.stop;
    waitfor(1'b1);
  endtask
  // Expected decodes
  function [4:0] thr_of(input [2:0] c);
    thr_of = {5'h0A, 5'h18, 5'h15, 5'h12, 5'h09, 5'h07, 5'h06,
      5'h00} >> (c * 5);
  endfunction
  function [9:0] hz_of(input [1:0] c);
    hz_of = 10'h073 << c;
  endfunction
  function [4:0] div_of(input [1:0] c);
    div_of = 5'h10 >> c;
  endfunction

  // Main sequence
  initial begin
    failures = 0;
    tests_run = 0;
    seed = $urandom(32'hE2CC);
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    waitfor(1'b0);
    check({angs, fields, BURN_COUNT}, 52'h0);
    check(PULSE_RATE_HZ, 10'h073);
    // Angles; reserved nibble written as ones must read back zero
    for (k = 0; k < 3; k = k + 1) begin
      v = 12'($urandom);
      v[11] = 1'b1;
      va[k] = v;
      wr2(8'(1 + 2 * k), {4'hF, v[11:8]}, v[7:0]);
      check(angs[35 - 12 * k -: 12], v);
      rd2(8'(1 + 2 * k));
      check({h, l}, {4'h0, v});
    end
    // Every threshold and rate code through read-modify-write
    sv = 14'h0000;
    for (k = 0; k < 8; k = k + 1) begin
      rd2(8'h07);
      check({h, l}, {2'h0, sv});
      sv = 14'($urandom);
      sv[12:10] = k[2:0];
      sv[7:6] = k[1:0];
      wr2(8'h07, {h[7:6], sv[13:8]}, sv[7:0]);
      check(fields, sv);
      check({FAST_THRESHOLD_LSB, PULSE_RATE_HZ, SLOW_FILTER_DIV},
        {thr_of(k[2:0]), hz_of(k[1:0]), div_of(sv[9:8])});
    end
    UNSCALED_ANGLE <= 12'($urandom);
    SCALED_ANGLE <= 12'($urandom);
    FIELD_STRENGTH <= 12'($urandom);
    GAIN_LEVEL <= 8'($urandom);
    {MAGNET_DETECTED, MAGNET_WEAK, MAGNET_STRONG} <= 3'h5;
    @(posedge CLK); // New inputs land first
    // Repeated reads of a high byte keep the pointer
    for (k = 0; k < 3; k = k + 1) begin
      v = k == 0 ? UNSCALED_ANGLE : k == 1 ? SCALED_ANGLE : FIELD_STRENGTH;
      setp(k == 0 ? 8'h0C : k == 1 ? 8'h0E : 8'h1B, 1'b1);
      rstart;
      for (n = 0; n < 3; n = n + 1) begin
        rdb(n == 2, l);
        check(l, {4'h0, v[11:8]});
      end
      i_bus_host.stop;
    end
    // Unassigned span reads zero up to the gain byte
    setp(8'h10, 1'b0);
    rstart;
    for (k = 16; k < 27; k = k + 1) begin
      rdb(k == 26, l);
      check(l, k == 26 ? GAIN_LEVEL : 8'h00);
    end
    i_bus_host.stop;
    // Discarded writes still move the pointer on to the flags
    setp(8'h09, 1'b0);
    wrb(8'h5A, 1'b0);
    wrb(8'hA5, 1'b0);
    rstart;
    rdb(1'b1, l);
    i_bus_host.stop;
    check(l, 8'h28);
    check(fields, sv);
    setp(8'h00, 1'b1);
    wrb(8'h03, 1'b0);
    i_bus_host.stop;
    rd2(8'h00);
    check(h, 8'h00);
    i_bus_host.start;
    i_bus_host.xfer({7'h37, 2'h1}, r);
    check(r[0], 1'b1);
    i_bus_host.stop;
    // Burns: angle burn refused without magnet, settings burn taken, then angle count saturating at three
    MAGNET_DETECTED <= 1'b0;
    cmd(8'h80);
    cmd(8'h01);
    check(BURN_COUNT, 2'h0);
    cmd(8'h40);
    MAGNET_DETECTED <= 1'b1;
    for (k = 1; k < 5; k = k + 1) begin
      cmd(8'h80);
      rd2(8'h00);
      check(h, k > 3 ? 3 : k);
    end
    wr2(8'h01, 8'h00, 8'h00);
    RST <= 1'b1;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    waitfor(1'b0);
    check({angs, fields, BURN_COUNT},
      {va[0], va[1], va[2], sv, 2'h3});
    finish_test;
  end
endmodule
